// [hw/sndc_top.sv]
// Signal and noise detector register file, readout and interrupt.
// Assumes a synchronous byte register port and one quality sample strobe.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "sndc_cfg.svh"
module sndc_top
  import sndc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic       clk_en_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Datapath quality inputs
  input  wire logic       sample_in,
  input  wire logic [7:0] ask_quality_value_in,
  input  wire logic [7:0] fsk_noise_value_in,
  input  wire logic [7:0] low_signal_value_in,
  // Operating context
  input  wire logic       config_sel_in,
  input  wire logic       wake_mode_in,
  // Results
  output logic            data_valid_out,
  output logic            signal_detect_out,
  output logic            noise_detect_out,
  output logic            irq_out
);
  logic [7:0] run_q   [2];
  logic [7:0] wake_q  [2];
  logic [7:0] ndcfg_q [2];
  logic [7:0] nthr_q  [2];
  logic [7:0] low_q   [2];
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_mask_q;
  logic       irq_q;
  logic [7:0] rdata_q;
  logic       valid_prev_q;
  logic       set_idx;
  logic [7:0] readout;
  logic       stat_rd;

  sndc_if ifc ();

  assign set_idx = config_sel_in;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 2; i++) begin
        run_q[i]   <= `SNDC_RST_REG;
        wake_q[i]  <= `SNDC_RST_REG;
        ndcfg_q[i] <= `SNDC_RST_REG;
        nthr_q[i]  <= `SNDC_RST_REG;
        low_q[i]   <= `SNDC_RST_REG;
      end
    end else if (clk_en_in && wr_in) begin
      case (addr_in)
        `SNDC_ADDR_RUN_A:   run_q[0]   <= wdata_in;
        `SNDC_ADDR_RUN_B:   run_q[1]   <= wdata_in;
        `SNDC_ADDR_WAKE_A:  wake_q[0]  <= wdata_in;
        `SNDC_ADDR_WAKE_B:  wake_q[1]  <= wdata_in;
        // Tuning bits are stored as written; the datapath sits outside this block
        `SNDC_ADDR_NDCFG_A: ndcfg_q[0] <= wdata_in;
        `SNDC_ADDR_NDCFG_B: ndcfg_q[1] <= wdata_in;
        `SNDC_ADDR_NTHR_A:  nthr_q[0]  <= wdata_in;
        `SNDC_ADDR_NTHR_B:  nthr_q[1]  <= wdata_in;
        `SNDC_ADDR_LOW_A:   low_q[0]   <= wdata_in;
        `SNDC_ADDR_LOW_B:   low_q[1]   <= wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_mask_q <= 2'h0;
    end else if (clk_en_in && wr_in && addr_in == `SNDC_ADDR_IRQ_MASK) begin
      irq_mask_q <= wdata_in[1:0];
    end
  end

  assign ifc.sample    = sample_in && clk_en_in;
  assign ifc.ask_q     = ask_quality_value_in;
  assign ifc.fsk_n     = fsk_noise_value_in;
  assign ifc.low_meas  = low_signal_value_in;
  assign ifc.wake      = wake_mode_in;
  assign ifc.run_thr   = run_q[set_idx][`SNDC_THR_MSB:`SNDC_THR_LSB];
  assign ifc.wake_thr  = wake_q[set_idx][`SNDC_THR_MSB:`SNDC_THR_LSB];
  assign ifc.run_cnt   = run_q[set_idx][`SNDC_CNT_MSB:`SNDC_CNT_LSB];
  assign ifc.wake_cnt  = wake_q[set_idx][`SNDC_CNT_MSB:`SNDC_CNT_LSB];
  assign ifc.mode      = sndc_mode_t'(ndcfg_q[set_idx][`SNDC_MODE_MSB:`SNDC_MODE_LSB]);
  assign ifc.noise_thr = nthr_q[set_idx];
  assign ifc.low_thr   = low_q[set_idx][`SNDC_THR_MSB:`SNDC_THR_LSB];

  sndc_decide u_sndc_decide (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .ifc        (ifc.dec)
  );

  assign readout = low_q[set_idx][`SNDC_LOW_RB_BIT] ? low_signal_value_in
                                                    : ask_quality_value_in;
  assign stat_rd = rd_in && addr_in == `SNDC_ADDR_IRQ_STAT;

  // Write-only registers read as zero so that reads never leak stale config
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else if (clk_en_in) begin
      if (rd_in) begin
        case (addr_in)
          `SNDC_ADDR_READOUT:  rdata_q <= readout;
          `SNDC_ADDR_STATE:    rdata_q <= {5'h00, ifc.noise_det, ifc.sig_det, ifc.valid};
          `SNDC_ADDR_IRQ_STAT: rdata_q <= {6'h00, irq_stat_q};
          `SNDC_ADDR_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
          default:             rdata_q <= 8'h00;
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // Set beats the read-clear so an edge in the read cycle is kept
  always_comb begin
    irq_stat_d = stat_rd ? 2'h0 : irq_stat_q;
    if (ifc.valid && !valid_prev_q) begin
      irq_stat_d[`SNDC_IRQ_RISE_BIT] = 1'b1;
    end
    if (!ifc.valid && valid_prev_q) begin
      irq_stat_d[`SNDC_IRQ_FALL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat_q   <= 2'h0;
      valid_prev_q <= 1'b0;
      irq_q        <= 1'b0;
    end else if (clk_en_in) begin
      irq_stat_q   <= irq_stat_d;
      valid_prev_q <= ifc.valid;
      irq_q        <= |(irq_stat_d & irq_mask_q);
    end
  end

  assign rdata_out         = rdata_q;
  assign data_valid_out    = ifc.valid;
  assign signal_detect_out = ifc.sig_det;
  assign noise_detect_out  = ifc.noise_det;
  assign irq_out           = irq_q;

  property p_run_store;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && wr_in && addr_in == `SNDC_ADDR_RUN_B |=> run_q[1] == $past(wdata_in);
  endproperty
  a_run_store: assert property (p_run_store) else $error("run copy B not stored");
  property p_run_apart;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && wr_in && addr_in == `SNDC_ADDR_RUN_A |=> run_q[1] == $past(run_q[1]);
  endproperty
  a_run_apart: assert property (p_run_apart) else $error("copy A write hit copy B");
  property p_readback_low;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && rd_in && addr_in == `SNDC_ADDR_READOUT && low_q[set_idx][7]
    |=> rdata_out == $past(low_signal_value_in);
  endproperty
  a_readback_low: assert property (p_readback_low) else $error("low readback wrong");
  property p_readback_ask;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && rd_in && addr_in == `SNDC_ADDR_READOUT && !low_q[set_idx][7]
    |=> rdata_out == $past(ask_quality_value_in);
  endproperty
  a_readback_ask: assert property (p_readback_ask) else $error("quality readback wrong");
  property p_sig_input;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && sample_in && !wake_mode_in && ifc.run_cnt == 2'h0 &&
    ask_quality_value_in <= {2'h0, ifc.run_thr} |=> !signal_detect_out;
  endproperty
  a_sig_input: assert property (p_sig_input) else $error("detect without quality");
  property p_irq_hold;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && ($rose(data_valid_out)) && irq_mask_q[0]
    |=> irq_out ##1 (irq_out || $past(stat_rd) || $past(wr_in));
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt not raised");
  c_irq: cover property (@(posedge mclk_in) disable iff (!reset_n_in) $rose(irq_out));
  c_low_rb: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    rd_in && addr_in == `SNDC_ADDR_READOUT && low_q[set_idx][7]);
endmodule : sndc_top

// [hw/sndc_cfg.svh]
// Register offsets, field positions and reset values of the detector block.
// Assumes byte-wide registers on an 8-bit address port.
`ifndef SNDC_CFG_SVH
`define SNDC_CFG_SVH
`define SNDC_ADDR_RUN_A     8'h71
`define SNDC_ADDR_WAKE_A    8'h72
`define SNDC_ADDR_NDCFG_A   8'h81
`define SNDC_ADDR_NTHR_A    8'h82
`define SNDC_ADDR_RUN_B     8'h91
`define SNDC_ADDR_WAKE_B    8'h92
`define SNDC_ADDR_NDCFG_B   8'ha1
`define SNDC_ADDR_NTHR_B    8'ha2
`define SNDC_ADDR_LOW_A     8'hb6
`define SNDC_ADDR_LOW_B     8'hb7
`define SNDC_ADDR_READOUT   8'hc0
`define SNDC_ADDR_STATE     8'hc1
`define SNDC_ADDR_IRQ_STAT  8'hc2
`define SNDC_ADDR_IRQ_MASK  8'hc3
`define SNDC_THR_MSB        5
`define SNDC_THR_LSB        0
`define SNDC_CNT_MSB        7
`define SNDC_CNT_LSB        6
`define SNDC_MODE_MSB       5
`define SNDC_MODE_LSB       4
`define SNDC_LOW_RB_BIT     7
`define SNDC_IRQ_RISE_BIT   0
`define SNDC_IRQ_FALL_BIT   1
`define SNDC_RST_REG        8'h00
`define SNDC_RST_CNT        2'h0
`endif

// [hw/sndc_pkg.sv]
// Types shared by the detector block.
// Assumes sndc_cfg.svh is on the include path.
package sndc_pkg;
  typedef enum logic [1:0] {
    SNDC_MODE_SIG     = 2'b00,
    SNDC_MODE_NOISE   = 2'b01,
    SNDC_MODE_BOTH    = 2'b10,
    SNDC_MODE_SIG_LOW = 2'b11
  } sndc_mode_t;
  typedef logic [5:0] sndc_thr_t;
  typedef logic [1:0] sndc_cnt_t;
endpackage : sndc_pkg

// [hw/sndc_if.sv]
// Carrier between register file and decision logic.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface sndc_if;
  import sndc_pkg::*;
  logic             sample;
  logic [7:0]       ask_q;
  logic [7:0]       fsk_n;
  logic [7:0]       low_meas;
  logic             wake;
  sndc_thr_t        run_thr;
  sndc_cnt_t        run_cnt;
  sndc_thr_t        wake_thr;
  sndc_cnt_t        wake_cnt;
  sndc_mode_t       mode;
  logic [7:0]       noise_thr;
  sndc_thr_t        low_thr;
  logic             sig_det;
  logic             noise_det;
  logic             valid;
  modport regs (output sample, ask_q, fsk_n, low_meas, wake, run_thr, run_cnt, wake_thr,
                output wake_cnt, mode, noise_thr, low_thr, input sig_det, noise_det, valid);
  modport dec  (input sample, ask_q, fsk_n, low_meas, wake, run_thr, run_cnt, wake_thr,
                input wake_cnt, mode, noise_thr, low_thr, output sig_det, noise_det, valid);
endinterface : sndc_if

// [hw/sndc_decide.sv]
// Signal and noise comparison, threshold counter and data-valid decision.
// Assumes the register file presents the active configuration set.
`timescale 1ns/10ps
`include "sndc_cfg.svh"
module sndc_decide
  import sndc_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  // Configuration and results
  sndc_if.dec       ifc
);
  function automatic logic above(input logic [7:0] v, input sndc_thr_t t);
    above = v > {2'h0, t};
  endfunction : above

  sndc_thr_t  thr;
  sndc_cnt_t  lim;
  logic       sig_above;
  logic       noise_below;
  logic       low_above;
  sndc_cnt_t  run_q;
  sndc_cnt_t  run_d;
  logic       sig_d;
  logic       valid_d;
  logic       sig_q;
  logic       noise_q;
  logic       valid_q;

  assign thr = ifc.wake ? ifc.wake_thr : ifc.run_thr;
  assign lim = ifc.wake ? ifc.wake_cnt : ifc.run_cnt;
  assign sig_above   = above(ifc.ask_q, thr);
  assign noise_below = ifc.fsk_n < ifc.noise_thr;
  assign low_above   = above(ifc.low_meas, ifc.low_thr);

  always_comb begin
    run_d = sig_above ? ((run_q == 2'h3) ? run_q : run_q + 2'h1) : 2'h0;
    sig_d = sig_above && ((lim == `SNDC_RST_CNT) || (run_d >= lim));
  end

  always_comb begin
    case (ifc.mode)
      SNDC_MODE_SIG:     valid_d = sig_d;
      SNDC_MODE_NOISE:   valid_d = noise_below;
      SNDC_MODE_BOTH:    valid_d = sig_d && noise_below;
      SNDC_MODE_SIG_LOW: valid_d = sig_d && noise_below && low_above;
      default:           valid_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_q   <= `SNDC_RST_CNT;
      sig_q   <= 1'b0;
      noise_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (clk_en_in && ifc.sample) begin
      run_q   <= run_d;
      sig_q   <= sig_d;
      noise_q <= noise_below;
      valid_q <= valid_d;
    end
  end

  assign ifc.sig_det   = sig_q;
  assign ifc.noise_det = noise_q;
  assign ifc.valid     = valid_q;

  property p_mode_sig;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && ifc.sample && ifc.mode == SNDC_MODE_SIG |=> ifc.valid == ifc.sig_det;
  endproperty
  a_mode_sig: assert property (p_mode_sig) else $error("valid differs from signal detect");
  property p_mode_noise;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && ifc.sample && ifc.mode == SNDC_MODE_NOISE |=> ifc.valid == ifc.noise_det;
  endproperty
  a_mode_noise: assert property (p_mode_noise) else $error("valid differs from noise");
  property p_run_thr;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && ifc.sample && !ifc.wake && ifc.run_cnt == 2'h0 &&
    ifc.ask_q > {2'h0, ifc.run_thr} |=> ifc.sig_det;
  endproperty
  a_run_thr: assert property (p_run_thr) else $error("run threshold missed");
  property p_wake_thr;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && ifc.sample && ifc.wake && ifc.ask_q <= {2'h0, ifc.wake_thr} |=> !ifc.sig_det;
  endproperty
  a_wake_thr: assert property (p_wake_thr) else $error("wake threshold ignored");
  property p_counter;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && ifc.sample && !ifc.wake && ifc.run_cnt == 2'h2 && run_q == 2'h0
    |=> !ifc.sig_det;
  endproperty
  a_counter: assert property (p_counter) else $error("counter did not delay detect");
  property p_noise;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && ifc.sample |=> ifc.noise_det == ($past(ifc.fsk_n) < $past(ifc.noise_thr));
  endproperty
  a_noise: assert property (p_noise) else $error("noise detect wrong");
  property p_low;
    @(posedge mclk_in) disable iff (!reset_n_in)
    clk_en_in && ifc.sample && ifc.mode == SNDC_MODE_SIG_LOW &&
    ifc.low_meas <= {2'h0, ifc.low_thr} |=> !ifc.valid;
  endproperty
  a_low: assert property (p_low) else $error("low threshold not applied");
  c_valid_rise: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(ifc.valid));
  c_low_mode: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    ifc.mode == SNDC_MODE_SIG_LOW && ifc.valid);
endmodule : sndc_decide

// [test/tb_sndc_top.sv]
// Self-checking bench for the detector register file and decision logic.
// Assumes the design files under hw/ and sndc_cfg.svh on the include path.
`timescale 1ns/10ps
`include "sndc_cfg.svh"
module tb_sndc_top;
  import sndc_pkg::*;
  logic       mclk_in;
  logic       reset_n_in;
  logic       clk_en_in;
  logic [7:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       sample_in;
  logic [7:0] ask_in;
  logic [7:0] fsk_in;
  logic [7:0] low_in;
  logic       config_sel_in;
  logic       wake_mode_in;
  logic       data_valid_out;
  logic       signal_detect_out;
  logic       noise_detect_out;
  logic       irq_out;
  int         n_fail;
  int         checked;
  logic [7:0] d;

  sndc_top u_sndc_top (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sample_in(sample_in), .ask_quality_value_in(ask_in),
    .fsk_noise_value_in(fsk_in), .low_signal_value_in(low_in),
    .config_sel_in(config_sel_in), .wake_mode_in(wake_mode_in),
    .data_valid_out(data_valid_out), .signal_detect_out(signal_detect_out),
    .noise_detect_out(noise_detect_out), .irq_out(irq_out));

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1;
    v = rdata_out;
  endtask : rd

  // Outputs are judged two cycles late, safe since they stand until the next sample
  task automatic samp(input logic [7:0] a, input logic [7:0] f, input logic [7:0] l);
    @(posedge mclk_in);
    sample_in <= 1'b1;
    ask_in    <= a;
    fsk_in    <= f;
    low_in    <= l;
    @(posedge mclk_in);
    sample_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask : samp

  task automatic t_reset_regs();
    rd(`SNDC_ADDR_RUN_A, d); chk(d, `SNDC_RST_REG);
    rd(`SNDC_ADDR_RUN_B, d); chk(d, `SNDC_RST_REG);
    wr(`SNDC_ADDR_RUN_A, 8'h3f);
    samp(8'h40, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h01);
    rd(`SNDC_ADDR_RUN_A, d); chk(d, 8'h00);
    rd(8'hff, d); chk(d, 8'h00);
  endtask : t_reset_regs

  task automatic t_modes();
    logic s, n, l, e;
    wr(`SNDC_ADDR_RUN_A, 8'h20);
    wr(`SNDC_ADDR_NTHR_A, 8'h40);
    // low threshold set with quality readout
    wr(`SNDC_ADDR_LOW_A, 8'h10);
    for (int m = 0; m < 4; m++) begin
      wr(`SNDC_ADDR_NDCFG_A, {2'b00, m[1:0], 4'b0111});
      for (int c = 0; c < 8; c++) begin
        s = c[0];
        n = c[1];
        l = c[2];
        samp(s ? 8'h21 : 8'h20, n ? 8'h3f : 8'h40, l ? 8'h11 : 8'h10);
        case (m)
          0: e = s;
          1: e = n;
          2: e = s & n;
          default: e = s & n & l;
        endcase
        chk({7'h0, signal_detect_out}, {7'h0, s});
        if (m == 1 || m == 2) chk({7'h0, noise_detect_out}, {7'h0, n});
        chk({7'h0, data_valid_out}, {7'h0, e});
      end
    end
    wr(`SNDC_ADDR_NDCFG_A, 8'h07);
  endtask : t_modes

  task automatic t_wake();
    wr(`SNDC_ADDR_WAKE_A, 8'h30);
    wake_mode_in <= 1'b1;
    samp(8'h30, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h00);
    samp(8'h31, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h01);
    wake_mode_in <= 1'b0;
    samp(8'h25, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h01);
  endtask : t_wake

  task automatic t_counter();
    wr(`SNDC_ADDR_RUN_A, {2'b10, 6'h20});
    samp(8'h00, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h00);
    samp(8'h21, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h00);
    samp(8'h21, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h01);
    wr(`SNDC_ADDR_RUN_A, 8'h20);
  endtask : t_counter

  task automatic t_set_b();
    wr(`SNDC_ADDR_RUN_B, 8'h05);
    wr(`SNDC_ADDR_NDCFG_B, 8'h07);
    config_sel_in <= 1'b1;
    samp(8'h06, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h01);
    samp(8'h05, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h00);
    config_sel_in <= 1'b0;
    samp(8'h06, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h00);
    // Clock enable low freezes the sample path
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    samp(8'h21, 8'h00, 8'h00); chk({7'h0, signal_detect_out}, 8'h00);
    clk_en_in <= 1'b1;
  endtask : t_set_b

  task automatic t_readback();
    int f;
    wr(`SNDC_ADDR_LOW_A, 8'h90);
    samp(8'h55, 8'h00, 8'h66);
    rd(`SNDC_ADDR_READOUT, d); chk(d, 8'h66);
    // range stepped until readout below 0x32
    f = 0;
    while (d >= 8'h32 && f < 4) begin
      f++;
      samp(8'h55, 8'h00, 8'hc8 >> f);
      rd(`SNDC_ADDR_READOUT, d); chk(d, 8'hc8 >> f);
    end
    chk(8'(f), 8'h03);
    wr(`SNDC_ADDR_LOW_A, 8'h10);
    samp(8'h55, 8'h00, 8'h66);
    rd(`SNDC_ADDR_READOUT, d); chk(d, 8'h55);
  endtask : t_readback

  task automatic t_irq();
    wr(`SNDC_ADDR_IRQ_MASK, 8'h01 << `SNDC_IRQ_RISE_BIT);
    samp(8'h00, 8'h00, 8'h00);
    rd(`SNDC_ADDR_IRQ_STAT, d); chk(d, 8'h03);
    rd(`SNDC_ADDR_IRQ_MASK, d); chk(d, 8'h01);
    repeat (2) @(posedge mclk_in);
    #1;
    chk({7'h0, irq_out}, 8'h00);
    samp(8'h21, 8'h00, 8'h00);
    @(posedge mclk_in);
    #1;
    chk({7'h0, irq_out}, 8'h01);
    rd(`SNDC_ADDR_IRQ_STAT, d); chk(d, 8'h01 << `SNDC_IRQ_RISE_BIT);
    repeat (2) @(posedge mclk_in);
    #1;
    chk({7'h0, irq_out}, 8'h00);
    // Fall event is masked, so status sets but the line stays low
    samp(8'h00, 8'h00, 8'h00);
    @(posedge mclk_in);
    #1;
    chk({7'h0, irq_out}, 8'h00);
    rd(`SNDC_ADDR_IRQ_STAT, d); chk(d, 8'h01 << `SNDC_IRQ_FALL_BIT);
    rd(`SNDC_ADDR_STATE, d); chk(d, 8'h04);
  endtask : t_irq

  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    end_of_test();
  end

  initial begin
    n_fail = 0;
    checked = 0;
    reset_n_in = 1'b0;
    clk_en_in = 1'b1;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    sample_in = 1'b0;
    ask_in = 8'h00;
    fsk_in = 8'h00;
    low_in = 8'h00;
    config_sel_in = 1'b0;
    wake_mode_in = 1'b0;
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    t_reset_regs();
    t_modes();
    t_wake();
    t_counter();
    t_set_b();
    t_readback();
    t_irq();
    end_of_test();
  end
endmodule : tb_sndc_top
